//--- verilog/tpo_pkg.sv
// constants shared by the time-proportioning output block
// Behaviour
// - the on/off waveform repeats every ten seconds whatever duty is commanded.
// - period timer advances once per 0.01 s tick and ends after 1000 ticks.
// - period timer restarts itself on reaching its preset, no trigger needed.
// - period end pulses one cycle and clears both the period and on-time counters.
// - at period end the control word is sampled to govern the next period.
// - the sample is divided by 4.095 and truncated, mapping 0..4095 onto 0..1000.
// - the scaled count becomes the on-time preset, replacing the previous one.
// - on-time timer counts the same tick; its preset ranges 0 up to 1000.
// - output high from period start until the on-time timer reaches its preset.
// - output forced low in the cycle the period end clears the on-time counter.
package tpo_pkg;

  // clock and tick timing, each time in its own unit
  localparam int unsigned CLK_PERIOD_NS = 8;
  localparam int unsigned TICK_NS       = 10_000_000;
  localparam int unsigned PERIOD_S      = 10;
  localparam int unsigned NS_PER_S      = 1_000_000_000;
  localparam int unsigned TICK_CYCLES   = TICK_NS / CLK_PERIOD_NS;
  localparam int unsigned PERIOD_TICKS_I = (PERIOD_S * (NS_PER_S / TICK_NS));

  // counter widths and presets
  localparam int unsigned CNT_W  = 10;
  localparam int unsigned WORD_W = 12;
  localparam logic [CNT_W-1:0]  PERIOD_TICKS = CNT_W'(PERIOD_TICKS_I);
  localparam logic [CNT_W-1:0]  ON_MAX       = 10'h3E8;
  localparam logic [WORD_W-1:0] WORD_FULL    = 12'hFFF;

  // divide by 4.095 done as multiply by 1000 then divide by 4095
  localparam int unsigned PROD_W    = 22;
  localparam logic [PROD_W-1:0] SCALE_MUL = 22'h0003E8;
  localparam logic [PROD_W-1:0] SCALE_DIV = 22'h000FFF;

  localparam logic [CNT_W-1:0] CNT_ZERO = 10'h000;

endpackage

//--- verilog/tpo_timer_if.sv
// carrier between the block and one tick timer
`timescale 1ns/1ps
interface tpo_timer_if #(parameter int W = 10);
  logic         tick;
  logic         clear;
  logic [W-1:0] preset;
  logic [W-1:0] count;
  logic         done;

  modport ctrl  (output tick, output clear, output preset, input count, input done);
  modport timer (input tick, input clear, input preset, output count, output done);
endinterface

//--- verilog/tpo_tick_timer.sv
// saturating up-counter of ticks with clear and preset compare
`timescale 1ns/1ps
module tpo_tick_timer #(
  parameter int W = 10
) (
  input wire logic  i_clk,
  input wire logic  i_nrst,
  tpo_timer_if.timer bus
);

  logic [W-1:0] next_count;

  always_comb
  begin
    next_count = bus.count;
    if (bus.clear)
      next_count = '0;
    else if (bus.tick && (bus.count < bus.preset))
      next_count = bus.count + W'(1);
  end

  always_ff @(posedge i_clk)
  begin
    if (!i_nrst)
      bus.count <= '0;
    else
      bus.count <= next_count;
  end

  // compare is combinational so a preset loaded with the clear is seen at once
  assign bus.done = (bus.count >= bus.preset);

  ////////////////////////////////////////////////////////////////////////////
  property p_clear_zero;
    @(posedge i_clk) disable iff (!i_nrst)
    bus.clear |=> (bus.count == '0);
  endproperty
  a_clear_zero: assert property (p_clear_zero) else $error("timer not cleared");

  property p_no_tick_hold;
    @(posedge i_clk) disable iff (!i_nrst)
    (!bus.tick && !bus.clear) |=> $stable(bus.count);
  endproperty
  a_no_tick_hold: assert property (p_no_tick_hold) else $error("timer moved without tick");

endmodule // tpo_tick_timer

//--- verilog/tpo_scaler.sv
// maps a 12-bit control word onto 0..1000 ticks
`timescale 1ns/1ps
module tpo_scaler (
  input  wire logic [tpo_pkg::WORD_W-1:0] i_word,
  output logic      [tpo_pkg::CNT_W-1:0]  o_ticks
);

  logic [tpo_pkg::PROD_W-1:0] prod;
  logic [tpo_pkg::PROD_W-1:0] quot;

  // truncation, not rounding: full scale lands exactly on 1000
  always_comb
  begin
    prod    = tpo_pkg::PROD_W'(i_word) * tpo_pkg::SCALE_MUL;
    quot    = prod / tpo_pkg::SCALE_DIV;
    o_ticks = quot[tpo_pkg::CNT_W-1:0];
  end

endmodule // tpo_scaler

//--- verilog/tpo_time_prop.sv
// time-proportioning on/off output driven by a control word
`timescale 1ns/1ps
module tpo_time_prop #(
  parameter int unsigned TICK_CYCLES = tpo_pkg::TICK_CYCLES
) (
  input  wire logic                       i_clk,
  input  wire logic                       i_nrst,
  input  wire logic [tpo_pkg::WORD_W-1:0] i_ctrl_word,
  output logic                            o_onoff,
  output logic                            o_period_end,
  output logic      [tpo_pkg::CNT_W-1:0]  o_on_preset
);

  ////////////////////////////////////////////////////////////////////////////
  // tick prescaler

  localparam logic [31:0] TICK_LAST = 32'(TICK_CYCLES - 1);

  logic [31:0] presc;
  logic [31:0] next_presc;
  logic        tick;

  // ticks run free, so a period is exactly a whole number of ticks
  always_comb
  begin
    if (presc == TICK_LAST)
      next_presc = '0;
    else
      next_presc = presc + 32'h0000_0001;
  end

  always_ff @(posedge i_clk)
  begin
    if (!i_nrst)
      presc <= '0;
    else
      presc <= next_presc;
  end

  assign tick = (presc == TICK_LAST);

  ////////////////////////////////////////////////////////////////////////////
  // period timer and on-time timer

  tpo_timer_if #(.W(tpo_pkg::CNT_W)) per_bus ();
  tpo_timer_if #(.W(tpo_pkg::CNT_W)) on_bus ();

  logic period_end;

  assign per_bus.tick   = tick;
  assign per_bus.preset = tpo_pkg::PERIOD_TICKS;
  // done feeds back as its own clear: self-restarting
  assign per_bus.clear  = per_bus.done;
  assign period_end     = per_bus.done;

  assign on_bus.tick    = tick;
  assign on_bus.clear   = period_end;

  tpo_tick_timer #(.W(tpo_pkg::CNT_W)) u_period_timer (
    .i_clk  (i_clk),
    .i_nrst (i_nrst),
    .bus    (per_bus)
  );

  tpo_tick_timer #(.W(tpo_pkg::CNT_W)) u_on_time_timer (
    .i_clk  (i_clk),
    .i_nrst (i_nrst),
    .bus    (on_bus)
  );

  ////////////////////////////////////////////////////////////////////////////
  // sample and scale the control word

  logic [tpo_pkg::CNT_W-1:0] scaled;
  logic [tpo_pkg::CNT_W-1:0] on_preset;
  logic [tpo_pkg::CNT_W-1:0] next_on_preset;

  tpo_scaler u_scaler (
    .i_word  (i_ctrl_word),
    .o_ticks (scaled)
  );

  // word is only looked at on the period-end cycle; changes in between are ignored
  always_comb
  begin
    next_on_preset = on_preset;
    if (period_end)
      next_on_preset = scaled;
  end

  always_ff @(posedge i_clk)
  begin
    if (!i_nrst)
      on_preset <= tpo_pkg::CNT_ZERO;
    else
      on_preset <= next_on_preset;
  end

  assign on_bus.preset = on_preset;

  ////////////////////////////////////////////////////////////////////////////
  // output stage

  logic next_onoff;
  logic next_period_end;

  // one cycle of latency, traded for a glitch-free registered pin
  always_comb
  begin
    next_onoff      = !on_bus.done && !period_end;
    next_period_end = period_end;
  end

  always_ff @(posedge i_clk)
  begin
    if (!i_nrst)
    begin
      o_onoff      <= 1'b0;
      o_period_end <= 1'b0;
    end
    else
    begin
      o_onoff      <= next_onoff;
      o_period_end <= next_period_end;
    end
  end

  assign o_on_preset = on_preset;

  ////////////////////////////////////////////////////////////////////////////
  // checks

  localparam logic [39:0] PERIOD_CYCLES = 40'(TICK_CYCLES) * 40'(tpo_pkg::PERIOD_TICKS);

  logic [39:0] cyc_since;
  logic [39:0] next_cyc_since;
  logic        seen_end;
  logic        next_seen_end;

  always_comb
  begin
    next_cyc_since = cyc_since + 40'h00_0000_0001;
    next_seen_end  = seen_end;
    if (period_end)
    begin
      next_cyc_since = '0;
      next_seen_end  = 1'b1;
    end
  end

  always_ff @(posedge i_clk)
  begin
    if (!i_nrst)
    begin
      cyc_since <= '0;
      seen_end  <= 1'b0;
    end
    else
    begin
      cyc_since <= next_cyc_since;
      seen_end  <= next_seen_end;
    end
  end

  property p_period_len;
    @(posedge i_clk) disable iff (!i_nrst)
    (period_end && seen_end) |-> (cyc_since == PERIOD_CYCLES - 40'h00_0000_0001);
  endproperty
  a_period_len: assert property (p_period_len) else $error("period length wrong");

  property p_end_at_preset;
    @(posedge i_clk) disable iff (!i_nrst)
    period_end |-> (per_bus.count == tpo_pkg::PERIOD_TICKS);
  endproperty
  a_end_at_preset: assert property (p_end_at_preset) else $error("period end off preset");

  property p_restart;
    @(posedge i_clk) disable iff (!i_nrst)
    period_end |=> (per_bus.count == tpo_pkg::CNT_ZERO) && !period_end;
  endproperty
  a_restart: assert property (p_restart) else $error("period timer did not restart");

  property p_end_clears_on;
    @(posedge i_clk) disable iff (!i_nrst)
    period_end |=> (on_bus.count == tpo_pkg::CNT_ZERO);
  endproperty
  a_end_clears_on: assert property (p_end_clears_on) else $error("on-time not cleared");

  property p_sample;
    @(posedge i_clk) disable iff (!i_nrst)
    period_end |=> (on_preset == $past(scaled));
  endproperty
  a_sample: assert property (p_sample) else $error("preset not sampled");

  property p_hold_preset;
    @(posedge i_clk) disable iff (!i_nrst)
    !period_end |=> $stable(on_preset);
  endproperty
  a_hold_preset: assert property (p_hold_preset) else $error("preset changed mid period");

  property p_scale_range;
    @(posedge i_clk) disable iff (!i_nrst)
    (scaled <= tpo_pkg::ON_MAX) && ((i_ctrl_word == tpo_pkg::WORD_FULL) == (scaled == tpo_pkg::ON_MAX));
  endproperty
  a_scale_range: assert property (p_scale_range) else $error("scaled value out of range");

  property p_on_bound;
    @(posedge i_clk) disable iff (!i_nrst)
    on_bus.count <= on_preset;
  endproperty
  a_on_bound: assert property (p_on_bound) else $error("on-time count past preset");

  property p_on_high;
    @(posedge i_clk) disable iff (!i_nrst)
    (!on_bus.done && !period_end) |=> o_onoff;
  endproperty
  a_on_high: assert property (p_on_high) else $error("output not high during on-time");

  property p_on_low;
    @(posedge i_clk) disable iff (!i_nrst)
    on_bus.done |=> !o_onoff;
  endproperty
  a_on_low: assert property (p_on_low) else $error("output high after on-time");

  property p_restart_low;
    @(posedge i_clk) disable iff (!i_nrst)
    period_end |=> !o_onoff && o_period_end;
  endproperty
  a_restart_low: assert property (p_restart_low) else $error("output high in restart cycle");

  property p_zero_low;
    @(posedge i_clk) disable iff (!i_nrst)
    (on_preset == tpo_pkg::CNT_ZERO) |=> !o_onoff;
  endproperty
  a_zero_low: assert property (p_zero_low) else $error("zero duty drove output");

  property p_full_high;
    @(posedge i_clk) disable iff (!i_nrst)
    (on_preset == tpo_pkg::ON_MAX && !period_end) |=> o_onoff;
  endproperty
  a_full_high: assert property (p_full_high) else $error("full duty dropped output");

  property p_presc_bound;
    @(posedge i_clk) disable iff (!i_nrst)
    presc <= TICK_LAST;
  endproperty
  a_presc_bound: assert property (p_presc_bound) else $error("prescaler past its last count");

  property p_pe_on_tick;
    @(posedge i_clk) disable iff (!i_nrst)
    period_end |-> $past(tick);
  endproperty
  a_pe_on_tick: assert property (p_pe_on_tick) else $error("period ended without a tick");

  property p_pe_pulse;
    @(posedge i_clk) disable iff (!i_nrst)
    o_period_end |=> !o_period_end;
  endproperty
  a_pe_pulse: assert property (p_pe_pulse) else $error("period end pulse too long");

  property p_pin_preset_range;
    @(posedge i_clk) disable iff (!i_nrst)
    o_on_preset <= tpo_pkg::ON_MAX;
  endproperty
  a_pin_preset_range: assert property (p_pin_preset_range) else $error("on-time preset above maximum");

  property p_on_saturate;
    @(posedge i_clk) disable iff (!i_nrst)
    (on_bus.done && !period_end) |=> $stable(on_bus.count);
  endproperty
  a_on_saturate: assert property (p_on_saturate) else $error("on-time count moved past preset");

  property p_start_high;
    @(posedge i_clk) disable iff (!i_nrst)
    (o_period_end && (o_on_preset != tpo_pkg::CNT_ZERO)) |=> o_onoff;
  endproperty
  a_start_high: assert property (p_start_high) else $error("output not raised at period start");

  property p_c_period;
    @(posedge i_clk) disable iff (!i_nrst)
    period_end && seen_end;
  endproperty
  c_period: cover property (p_c_period);

  property p_c_fall;
    @(posedge i_clk) disable iff (!i_nrst)
    $fell(o_onoff) && !o_period_end;
  endproperty
  c_fall: cover property (p_c_fall);

  property p_c_full;
    @(posedge i_clk) disable iff (!i_nrst)
    period_end && (scaled == tpo_pkg::ON_MAX);
  endproperty
  c_full: cover property (p_c_full);

  property p_c_zero;
    @(posedge i_clk) disable iff (!i_nrst)
    period_end && (scaled == tpo_pkg::CNT_ZERO) && seen_end;
  endproperty
  c_zero: cover property (p_c_zero);

  property p_c_mid;
    @(posedge i_clk) disable iff (!i_nrst)
    period_end && seen_end && (scaled != tpo_pkg::CNT_ZERO) && (scaled != tpo_pkg::ON_MAX);
  endproperty
  c_mid: cover property (p_c_mid);

endmodule // tpo_time_prop

//--- test/tpo_ctrl_model.sv
// behavioural loop controller that presents the control word
`timescale 1ns/1ps
module tpo_ctrl_model #(
  parameter int PC = 4000
) (
  input  wire logic                       i_clk,
  input  wire logic                       i_period_end,
  input  wire logic [tpo_pkg::WORD_W-1:0] i_next,
  input  wire logic [tpo_pkg::WORD_W-1:0] i_junk,
  output logic      [tpo_pkg::WORD_W-1:0] o_word
);
  int                         cnt = 0;
  logic [tpo_pkg::WORD_W-1:0] word_q = 12'h000;

  assign o_word = word_q;

  // junk just after the taken edge, real value only half a cycle before the next
  always @(negedge i_clk)
  begin
    if (i_period_end === 1'b1)
    begin
      cnt    <= 1;
      word_q <= i_junk;
    end
    else
    begin
      cnt <= cnt + 1;
      if (cnt == PC - 1)
        word_q <= i_next;
    end
  end
endmodule // tpo_ctrl_model

//--- test/time_proportioning_output_test.sv
// self-checking bench for the time-proportioning output
`timescale 1ns/1ps
module time_proportioning_output_test;
  localparam int T  = 4;
  localparam int PC = tpo_pkg::PERIOD_TICKS_I * T;
  logic                       i_clk = 1'b0;
  logic                       i_nrst = 1'b0;
  logic [tpo_pkg::WORD_W-1:0] word;
  logic [tpo_pkg::WORD_W-1:0] w_taken = 12'h000;
  logic [tpo_pkg::WORD_W-1:0] nxt = 12'h000;
  logic [tpo_pkg::WORD_W-1:0] junk = 12'h000;
  logic                       o_onoff;
  logic                       o_period_end;
  logic [tpo_pkg::CNT_W-1:0]  o_on_preset;
  logic [tpo_pkg::WORD_W-1:0] vec [12];
  int n_mismatch = 0;
  int checks_done = 0;
  int c = 0;
  int p_exp = 0;
  bit synced = 0;

  always #4 i_clk = ~i_clk;

  tpo_time_prop #(.TICK_CYCLES(T)) u_tpo_time_prop (
    .i_clk        (i_clk),
    .i_nrst       (i_nrst),
    .i_ctrl_word  (word),
    .o_onoff      (o_onoff),
    .o_period_end (o_period_end),
    .o_on_preset  (o_on_preset)
  );

  tpo_ctrl_model #(.PC(PC)) u_tpo_ctrl_model (
    .i_clk        (i_clk),
    .i_period_end (o_period_end),
    .i_next       (nxt),
    .i_junk       (junk),
    .o_word       (word)
  );

  ////////////////////////////////////////////////////////////////////////
  // truncating divide by 4.095, kept in integers
  function automatic int scale(input logic [11:0] w);
    return (int'(w) * 1000) / 4095;
  endfunction

  task automatic chk_bit(input logic got, input logic exp);
    checks_done++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("Error at %0t: output bit %b, expected %b", $time, got, exp);
    end
  endtask

  task automatic chk_val(input logic [15:0] got, input logic [15:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("Error at %0t: value %0d, expected %0d", $time, got, exp);
    end
  endtask

  task automatic give_verdict;
    if (n_mismatch == 0 && checks_done > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  task automatic wait_pe;
    int k;
    for (k = 0; k < 2 * PC && o_period_end !== 1'b1; k++)
      @(negedge i_clk);
    if (o_period_end !== 1'b1)
    begin
      n_mismatch++;
      $display("Error at %0t: no period end seen", $time);
    end
  endtask

  ////////////////////////////////////////////////////////////////////////
  // the word at the edge before the pulse is the one the design took
  always @(posedge i_clk)
    w_taken <= word;

  always @(negedge i_clk)
  begin
    if (i_nrst)
    begin
      if (o_period_end === 1'b1)
      begin
        if (synced)
          chk_val(16'(c), 16'(PC));
        c = 1;
        synced = 1;
        p_exp = scale(w_taken);
      end
      else
        c++;
      if (synced)
      begin
        chk_val(16'(o_on_preset), 16'(p_exp));
        chk_bit(o_onoff, c >= 2 && c <= p_exp * T);
      end
      else
        chk_bit(o_onoff, 1'b0);
    end
  end

  initial
  begin
    repeat (80000) @(posedge i_clk);
    n_mismatch++;
    give_verdict();
  end

  initial
  begin
    int i;
    void'($urandom(32'h64c2f9a8));
    vec = '{12'h000, 12'hFFF, 12'h800, 12'h001, 12'hFFE, 12'h004,
            12'h005, 12'hFFF, 12'h000, 12'h000, 12'h000, 12'h000};
    // last four entries replaced by random words
    for (i = 8; i < 12; i++)
      vec[i] = 12'($urandom);
    repeat (10) @(negedge i_clk);
    i_nrst <= 1'b1;
    for (i = 0; i < 12; i++)
    begin
      wait_pe();
      nxt  <= vec[i];
      junk <= 12'($urandom);
      @(negedge i_clk);
    end
    wait_pe();
    @(negedge i_clk);
    wait_pe();
    repeat (2) @(negedge i_clk);
    give_verdict();
  end
endmodule // time_proportioning_output_test
